// [core/sepcl_map.svh]
/*
  Constants of the serial EEPROM command and protection logic: opcodes,
  status bit positions, protection boundaries, array geometry and timing.
  Assumes it is included by its bare name from the package; the top module only uses its macros.
*/
// Functional notes
// - Pin low plus enable bit refuses status writes.
// - Guard bits protect none, quarter, half, all.
// - Input bits captured on rising serial clock.
// - Output bits change after falling serial clock.
// - Read address increments per byte, wraps.
// - Chip select rise ends read, stops shifting.
// - Latch set only by complete eight-bit enable.
// - Write data wraps inside its 32-byte page.
// - Write starts only on whole-byte boundary rise.
// - Status readable while busy, array data not.
// - Completed write cycle clears the enable latch.
// - Array commands ignored during internal write.
// - Reset gives standby, cleared latch, floating output.
// - Select rise floats output; programming still finishes.
// - Select rise after valid sequence starts programming.
// - Protect pin cannot disturb running write.
// - Enable bit clear makes protect pin ignored.
// - Pause takes effect with clock low.
// - Paused: output floats, inputs ignored, resumes.
// - Opcode values for the six commands.
// - Status byte bit layout.
// - Everything shifts most significant bit first.
// - Programming lasts at most 5 ms, busy shown.
`ifndef SEPCL_MAP_SVH
`define SEPCL_MAP_SVH
`define SEPCL_OP_SET_LATCH 8'h06
`define SEPCL_OP_CLR_LATCH 8'h04
`define SEPCL_OP_RD_STATUS 8'h05
`define SEPCL_OP_WR_STATUS 8'h01
`define SEPCL_OP_RD_ARRAY 8'h03
`define SEPCL_OP_WR_ARRAY 8'h02
`define SEPCL_ST_PPE 7
`define SEPCL_ST_BGH 3
`define SEPCL_ST_BGL 2
`define SEPCL_ST_WEL 1
`define SEPCL_ST_WIP 0
`define SEPCL_GUARD_QTR 12'hC00
`define SEPCL_GUARD_HALF 12'h800
`define SEPCL_ADDR_LAST 12'hFFF
`define SEPCL_ADDR_FIRST 12'h000
`define SEPCL_ADDR_W 12
`define SEPCL_PAGE_W 5
`define SEPCL_PAGE_LAST 5'h1F
`define SEPCL_ARRAY_BYTES 4096
`define SEPCL_STATUS_RST 8'h00
`define SEPCL_PROG_TIME_US 5000
`define SEPCL_CLK_PERIOD_NS 8
`endif

// [core/sepcl_pkg.sv]
/*
  Types shared by the serial EEPROM command logic: command codes, phase
  and programming states, and the state record of the serial-clock side.
  Assumes the constants header sits beside it.
*/
package sepcl_pkg;
`include "sepcl_map.svh"

  // Decoded command.
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_SET_LATCH = 3'h1,
    OP_CLR_LATCH = 3'h2,
    OP_RD_STATUS = 3'h3,
    OP_WR_STATUS = 3'h4,
    OP_RD_ARRAY = 3'h5,
    OP_WR_ARRAY = 3'h6,
    OP_UNKNOWN = 3'h7
  } sepcl_op_t;

  // Where the serial sequence stands.
  typedef enum logic [4:0] {
    PH_CMD = 5'h01,
    PH_ADDR_HI = 5'h02,
    PH_ADDR_LO = 5'h04,
    PH_DATA = 5'h08,
    PH_IGNORE = 5'h10
  } sepcl_phase_t;

  // Programming engine states.
  typedef enum logic [2:0] {
    MD_IDLE = 3'h1,
    MD_COPY = 3'h2,
    MD_PROG = 3'h4
  } sepcl_mode_t;

  // Link state clocked by the rising serial clock.
  typedef struct packed {
    sepcl_phase_t phase;
    sepcl_op_t op;
    logic [2:0] bitcnt;
    logic [7:0] sh;
    logic [`SEPCL_ADDR_W-1:0] addr;
    logic [7:0] tx;
    logic drive;
    logic ok;
    logic [31:0][7:0] page;
    logic [31:0] mask;
  } sepcl_link_t;
endpackage

// [core/sepcl_sync.sv]
/*
  Two-flip-flop synchroniser for levels of any width.
  Assumes each bit is a slow level; the first stage feeds only the second.
*/
`timescale 1ns/1ns
module sepcl_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } sepcl_sync_t;

  sepcl_sync_t sync_ff;
  sepcl_sync_t nxt_sync;

  // Stage one only feeds stage two.
  always_comb begin
    nxt_sync.s1 = d_i;
    nxt_sync.s2 = sync_ff.s1;
  end

  // Both stages take the reset value.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_ff <= {RST_VAL, RST_VAL};
    end else begin
      sync_ff <= nxt_sync;
    end
  end

  assign q_o = sync_ff.s2;
endmodule

// [core/sepcl_top.sv]
/*
  Command, addressing, protection and programming logic of a 4096-byte serial
  EEPROM. The link side runs on the master's serial clock; programming and
  the array run on clock_i. Assumes the master holds select low through each
  frame and keeps the serial clock still while select is high.
*/
`timescale 1ns/1ns
module sepcl_top
  import sepcl_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = (`SEPCL_PROG_TIME_US * 1000) / `SEPCL_CLK_PERIOD_NS
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  output logic so_o,
  output logic so_oe_o,
  output logic write_in_progress_o,
  output logic write_enable_latch_o,
  output logic protect_pin_enable_o,
  output logic block_guard_hi_o,
  output logic block_guard_lo_o
);
  localparam int TW = $clog2(PROG_CYCLES + 1);
  localparam logic [7:0] STATUS_RST = `SEPCL_STATUS_RST;

  typedef struct packed {
    sepcl_mode_t mode;
    logic cs_prev;
    logic seen;
    logic write_enable_latch;
    logic protect_pin_enable;
    logic [1:0] bp;
    logic [`SEPCL_PAGE_W-1:0] idx;
    logic [TW-1:0] timer;
  } sepcl_core_t;

  typedef struct packed {
    logic so;
  } sepcl_fall_t;

  logic rst_q_n;
  logic cs_q;
  logic wp_q;
  logic [7:0] status_c;
  logic [7:0] status_l;
  logic busy_l;
  logic pause;
  logic held_ff;
  logic fresh_ff;
  logic fresh_set;
  logic cs_rise;
  logic busy;
  logic mem_we;
  logic [`SEPCL_ADDR_W-1:0] mem_wa;
  logic [7:0] byte_in;
  sepcl_link_t base;
  sepcl_link_t lnk_ff;
  sepcl_link_t nxt_lnk;
  sepcl_fall_t fall_ff;
  sepcl_fall_t nxt_fall;
  sepcl_core_t core_ff;
  sepcl_core_t nxt_core;
  logic [7:0] mem [`SEPCL_ARRAY_BYTES];

  // Map a received byte to a command.
  function automatic sepcl_op_t op_decode(input logic [7:0] b);
    case (b)
      `SEPCL_OP_SET_LATCH: op_decode = OP_SET_LATCH;
      `SEPCL_OP_CLR_LATCH: op_decode = OP_CLR_LATCH;
      `SEPCL_OP_RD_STATUS: op_decode = OP_RD_STATUS;
      `SEPCL_OP_WR_STATUS: op_decode = OP_WR_STATUS;
      `SEPCL_OP_RD_ARRAY: op_decode = OP_RD_ARRAY;
      `SEPCL_OP_WR_ARRAY: op_decode = OP_WR_ARRAY;
      default: op_decode = OP_UNKNOWN;
    endcase
  endfunction

  // True when an array address lies in the guarded block.
  function automatic logic guarded(input logic [`SEPCL_ADDR_W-1:0] a, input logic [1:0] bp);
    case (bp)
      2'h1: guarded = (a >= `SEPCL_GUARD_QTR);
      2'h2: guarded = (a >= `SEPCL_GUARD_HALF);
      2'h3: guarded = 1'b1;
      default: guarded = 1'b0;
    endcase
  endfunction

  // Reset release, pin levels into clock_i, status into the serial domain.
  sepcl_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
    .clk_i(clock_i),
    .rst_n_i(rst_n_i),
    .d_i(1'b1),
    .q_o(rst_q_n)
  );
  sepcl_sync #(.W(2), .RST_VAL(2'h3)) u_pin_sync (
    .clk_i(clock_i),
    .rst_n_i(rst_q_n),
    .d_i({cs_n_i, wp_n_i}),
    .q_o({cs_q, wp_q})
  );
  sepcl_sync #(.W(8), .RST_VAL(`SEPCL_STATUS_RST)) u_stat_sync (
    .clk_i(sck_i),
    .rst_n_i(rst_q_n),
    .d_i(status_c),
    .q_o(status_l)
  );

  // Status byte in its documented layout.
  always_comb begin
    status_c = 8'h00;
    status_c[`SEPCL_ST_PPE] = core_ff.protect_pin_enable;
    status_c[`SEPCL_ST_BGH] = core_ff.bp[1];
    status_c[`SEPCL_ST_BGL] = core_ff.bp[0];
    status_c[`SEPCL_ST_WEL] = core_ff.write_enable_latch;
    status_c[`SEPCL_ST_WIP] = busy;
  end

  assign busy_l = status_l[`SEPCL_ST_WIP];

  // Pause: hold low with the clock low acts at once; a high phase keeps what its rise saw.
  assign pause = !cs_n_i && (sck_i ? held_ff : !hold_n_i);

  // A new frame starts fresh; select high presets this flag.
  assign fresh_set = cs_n_i || !rst_q_n;

  always_ff @(posedge sck_i or posedge fresh_set) begin
    if (fresh_set) begin
      fresh_ff <= 1'b1;
    end else begin
      fresh_ff <= hold_n_i ? 1'b0 : fresh_ff;
    end
  end

  // Serial-side sequencing on the rising serial clock.
  always_comb begin
    base = lnk_ff;
    if (fresh_ff) begin
      base.phase = PH_CMD;
      base.bitcnt = 3'h0;
      base.ok = 1'b0;
      base.drive = 1'b0;
      base.mask = 32'h0000_0000;
    end
    byte_in = {base.sh[6:0], si_i};
    nxt_lnk = base;
    nxt_lnk.sh = byte_in;
    nxt_lnk.bitcnt = base.bitcnt + 3'h1;
    nxt_lnk.ok = 1'b0;
    if (base.bitcnt == 3'h7) begin
      case (base.phase)
        PH_CMD: begin
          nxt_lnk.op = op_decode(byte_in);
          if (busy_l && op_decode(byte_in) != OP_RD_STATUS) begin
            nxt_lnk.phase = PH_IGNORE;
          end else begin
            case (op_decode(byte_in))
              OP_SET_LATCH, OP_CLR_LATCH: begin
                nxt_lnk.phase = PH_IGNORE;
                nxt_lnk.ok = 1'b1;
              end
              OP_RD_STATUS: begin
                nxt_lnk.phase = PH_DATA;
                nxt_lnk.tx = status_l;
                nxt_lnk.drive = 1'b1;
              end
              OP_WR_STATUS: nxt_lnk.phase = PH_DATA;
              OP_RD_ARRAY, OP_WR_ARRAY: nxt_lnk.phase = PH_ADDR_HI;
              default: nxt_lnk.phase = PH_IGNORE;
            endcase
          end
        end
        PH_ADDR_HI: begin
          nxt_lnk.addr[11:8] = byte_in[3:0];
          nxt_lnk.phase = PH_ADDR_LO;
        end
        PH_ADDR_LO: begin
          nxt_lnk.addr = {base.addr[11:8], byte_in};
          nxt_lnk.phase = PH_DATA;
          if (base.op == OP_RD_ARRAY) begin
            nxt_lnk.tx = mem[{base.addr[11:8], byte_in}];
            nxt_lnk.drive = 1'b1;
          end
        end
        PH_DATA: begin
          case (base.op)
            OP_RD_ARRAY: begin
              nxt_lnk.addr = base.addr + 12'h001;
              nxt_lnk.tx = mem[base.addr + 12'h001];
            end
            OP_RD_STATUS: nxt_lnk.tx = status_l;
            OP_WR_ARRAY: begin
              nxt_lnk.page[base.addr[4:0]] = byte_in;
              nxt_lnk.mask[base.addr[4:0]] = 1'b1;
              nxt_lnk.addr[4:0] = base.addr[4:0] + 5'h01;
              nxt_lnk.ok = 1'b1;
            end
            OP_WR_STATUS: begin
              if (base.mask[0]) begin
                nxt_lnk.phase = PH_IGNORE;
              end else begin
                nxt_lnk.mask[0] = 1'b1;
                nxt_lnk.ok = 1'b1;
              end
            end
            default: nxt_lnk.phase = PH_IGNORE;
          endcase
        end
        PH_IGNORE: nxt_lnk.phase = PH_IGNORE;
        default: nxt_lnk.phase = PH_IGNORE;
      endcase
    end
    if (!hold_n_i) begin
      nxt_lnk = lnk_ff;
    end
  end

  always_ff @(posedge sck_i or negedge rst_q_n) begin
    if (!rst_q_n) begin
      lnk_ff <= '0;
      held_ff <= 1'b0;
    end else begin
      lnk_ff <= nxt_lnk;
      held_ff <= !hold_n_i;
    end
  end

  // Output bit on the falling serial clock; a fall with the pause pin low keeps it.
  always_comb begin
    nxt_fall.so = fall_ff.so;
    if (hold_n_i) begin
      nxt_fall.so = lnk_ff.tx[3'h7 - lnk_ff.bitcnt];
    end
  end

  always_ff @(negedge sck_i or negedge rst_q_n) begin
    if (!rst_q_n) begin
      fall_ff <= 1'b1;
    end else begin
      fall_ff <= nxt_fall;
    end
  end

  assign so_o = fall_ff.so;
  // Output floats at once when deselected, paused or not answering.
  assign so_oe_o = !cs_n_i && !pause && !fresh_ff && lnk_ff.drive;

  // Programming engine. Link fields are frozen while select stays high.
  assign cs_rise = cs_q && !core_ff.cs_prev && core_ff.seen;
  assign busy = (core_ff.mode != MD_IDLE);

  always_comb begin
    nxt_core = core_ff;
    nxt_core.cs_prev = cs_q;
    mem_we = 1'b0;
    mem_wa = {lnk_ff.addr[11:5], core_ff.idx};
    if (!cs_q) begin
      nxt_core.seen = 1'b1;
    end
    case (core_ff.mode)
      MD_IDLE: begin
        if (cs_rise && lnk_ff.ok) begin
          case (lnk_ff.op)
            OP_SET_LATCH: nxt_core.write_enable_latch = 1'b1;
            OP_CLR_LATCH: nxt_core.write_enable_latch = 1'b0;
            OP_WR_STATUS: begin
              if (core_ff.write_enable_latch && !(core_ff.protect_pin_enable && !wp_q)) begin
                nxt_core.protect_pin_enable = lnk_ff.sh[`SEPCL_ST_PPE];
                nxt_core.bp = {lnk_ff.sh[`SEPCL_ST_BGH], lnk_ff.sh[`SEPCL_ST_BGL]};
                nxt_core.mode = MD_PROG;
                nxt_core.timer = '0;
              end
            end
            OP_WR_ARRAY: begin
              if (core_ff.write_enable_latch && !guarded(lnk_ff.addr, core_ff.bp)) begin
                nxt_core.mode = MD_COPY;
                nxt_core.idx = 5'h00;
                nxt_core.timer = '0;
              end
            end
            default: nxt_core.mode = MD_IDLE;
          endcase
        end
      end
      MD_COPY: begin
        mem_we = lnk_ff.mask[core_ff.idx];
        nxt_core.idx = core_ff.idx + 5'h01;
        nxt_core.timer = core_ff.timer + TW'(1);
        if (core_ff.idx == `SEPCL_PAGE_LAST) begin
          nxt_core.mode = MD_PROG;
        end
      end
      MD_PROG: begin
        nxt_core.timer = core_ff.timer + TW'(1);
        if (core_ff.timer == TW'(PROG_CYCLES - 1)) begin
          nxt_core.mode = MD_IDLE;
          nxt_core.write_enable_latch = 1'b0;
        end
      end
      default: nxt_core.mode = MD_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_q_n) begin
    if (!rst_q_n) begin
      core_ff <= {MD_IDLE, 1'b1, 1'b0, 1'b0, STATUS_RST[7], STATUS_RST[3:2], 5'h00, TW'(0)};
    end else begin
      core_ff <= nxt_core;
    end
  end

  // Array storage, written one page byte per cycle.
  always_ff @(posedge clock_i) begin
    if (mem_we) begin
      mem[mem_wa] <= lnk_ff.page[core_ff.idx];
    end
  end

  assign write_in_progress_o = busy;
  assign write_enable_latch_o = core_ff.write_enable_latch;
  assign protect_pin_enable_o = core_ff.protect_pin_enable;
  assign block_guard_hi_o = core_ff.bp[1];
  assign block_guard_lo_o = core_ff.bp[0];

  // Checks on the programming engine.
  prog_bound_a: assert property (@(posedge clock_i) disable iff (!rst_q_n)
    busy |-> core_ff.timer < TW'(PROG_CYCLES)) else $error("Programming ran past its time.");
  wel_clear_a: assert property (@(posedge clock_i) disable iff (!rst_q_n)
    $fell(busy) |-> !core_ff.write_enable_latch) else $error("Latch still set after programming.");
  wel_set_a: assert property (@(posedge clock_i) disable iff (!rst_q_n)
    $rose(core_ff.write_enable_latch) |-> $past(cs_rise) && $past(lnk_ff.op) == OP_SET_LATCH && $past(lnk_ff.ok))
    else $error("Latch set without a complete enable.");
  start_cs_a: assert property (@(posedge clock_i) disable iff (!rst_q_n)
    $rose(busy) |-> $past(cs_rise) && $past(lnk_ff.ok)) else $error("Programming began without select rise.");
  wp_refuse_a: assert property (@(posedge clock_i) disable iff (!rst_q_n)
    cs_rise && !busy && lnk_ff.op == OP_WR_STATUS && core_ff.protect_pin_enable && !wp_q |=> !busy && $stable(core_ff.bp))
    else $error("Status write passed the protect pin.");
  guard_write_a: assert property (@(posedge clock_i) disable iff (!rst_q_n)
    mem_we |-> !guarded(mem_wa, core_ff.bp)) else $error("Guarded byte written.");
  prog_keep_a: assert property (@(posedge clock_i) disable iff (!rst_q_n)
    core_ff.mode == MD_PROG && !wp_q && core_ff.timer != TW'(PROG_CYCLES - 1) |=> core_ff.mode == MD_PROG)
    else $error("Protect pin disturbed programming.");

  // Checks on the serial side.
  read_wrap_a: assert property (@(posedge sck_i) disable iff (!rst_q_n)
    !pause && !fresh_ff && lnk_ff.phase == PH_DATA && lnk_ff.op == OP_RD_ARRAY && lnk_ff.bitcnt == 3'h7
    && lnk_ff.addr == `SEPCL_ADDR_LAST |=> lnk_ff.addr == `SEPCL_ADDR_FIRST) else $error("Read did not wrap.");
  page_wrap_a: assert property (@(posedge sck_i) disable iff (!rst_q_n)
    !pause && !fresh_ff && lnk_ff.phase == PH_DATA && lnk_ff.op == OP_WR_ARRAY && lnk_ff.bitcnt == 3'h7
    && lnk_ff.addr[4:0] == `SEPCL_PAGE_LAST |=> lnk_ff.addr[4:0] == 5'h00 && $stable(lnk_ff.addr[11:5]))
    else $error("Page address left its page.");
  busy_ignore_a: assert property (@(posedge sck_i) disable iff (!rst_q_n)
    !pause && !fresh_ff && busy_l && lnk_ff.phase == PH_CMD && lnk_ff.bitcnt == 3'h7
    && op_decode({lnk_ff.sh[6:0], si_i}) == OP_RD_ARRAY |=> lnk_ff.phase == PH_IGNORE && !lnk_ff.drive)
    else $error("Array read accepted while busy.");
  bad_op_a: assert property (@(posedge sck_i) disable iff (!rst_q_n)
    !pause && !fresh_ff && lnk_ff.phase == PH_CMD && lnk_ff.bitcnt == 3'h7
    && op_decode({lnk_ff.sh[6:0], si_i}) == OP_UNKNOWN |=> lnk_ff.phase == PH_IGNORE [*2])
    else $error("Unknown opcode not ignored.");
  pause_stall_a: assert property (@(posedge sck_i) disable iff (!rst_q_n)
    pause |=> $stable(lnk_ff) && $stable(fresh_ff)) else $error("State moved while paused.");

  // Main scenarios.
  cov_wel: cover property (@(posedge clock_i) disable iff (!rst_q_n) $rose(core_ff.write_enable_latch));
  cov_copy: cover property (@(posedge clock_i) disable iff (!rst_q_n) core_ff.mode == MD_COPY && mem_we);
  cov_status: cover property (@(posedge clock_i) disable iff (!rst_q_n)
    cs_rise && lnk_ff.op == OP_WR_STATUS ##1 busy);
  cov_pause: cover property (@(posedge sck_i) disable iff (!rst_q_n) pause && lnk_ff.phase == PH_DATA);
endmodule

// [testbench/sepcl_master.sv]
/*
  Behavioural serial master for the EEPROM command logic: frames, bits and pause.
  Assumes mode 0 timing with a 125 ns serial clock that stands low between frames.
*/
`timescale 1ns/1ns
module sepcl_master (
  input wire logic so_i,
  input wire logic so_oe_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  output logic hold_n_o
);
  logic last_so;
  logic oe_seen;

  // Idle pins: deselected, clock low, no pause.
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    hold_n_o = 1'b1;
    last_so = 1'b0;
    oe_seen = 1'b0;
  end

  // Selects the device; the first rise that follows carries bit 7.
  task automatic start();
    cs_n_o = 1'b0;
    oe_seen = 1'b0;
    #63;
  endtask

  // Deselects after the last fall, then keeps the link quiet for 50 system clocks.
  task automatic stop();
    #63 cs_n_o = 1'b1;
    si_o = ~si_o;
    #400;
  endtask

  // Shifts nb bits; data is set while the clock is low and read back at the rise.
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      si_o = tx[i];
      #62 sck_o = 1'b1;
      rx[i] = (so_oe_i === 1'b1) ? so_i : ~last_so; // A released line shows the inverse of its last value.
      if (so_oe_i === 1'b1) begin
        oe_seen = 1'b1;
        last_so = so_i;
      end
      #63 sck_o = 1'b0;
    end
  endtask

  // Pauses with the clock low, clocks junk while paused, resumes with the clock low.
  task automatic pause(input int n, output logic oe);
    #30 hold_n_o = 1'b0;
    #30 oe = so_oe_i;
    repeat (n) begin
      si_o = ~si_o;
      #62 sck_o = 1'b1;
      #63 sck_o = 1'b0;
    end
    #30 hold_n_o = 1'b1;
    #30;
  endtask
endmodule

// [testbench/sepcl_top_tb.sv]
/*
  Self-checking bench: latch, status, page write, protection, read wrap and pause.
  Assumes the serial master model and a shortened programming time.
*/
`timescale 1ns/1ns
module sepcl_top_tb;
  localparam int PROG = 2000;
  logic clock_i, rst_n_i, wp_n_i;
  logic sck, cs_n, si, hold_n, so, so_oe, write_in_progress, write_enable_latch, ppe_o, bgh, bgl;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [7:0] mem [0:4095];
  logic [11:0] tgt [4] = '{12'h7FF, 12'h800, 12'hBFF, 12'hC00};
  logic [1:0] bg = 2'b00;
  logic ppe = 1'b0;
  logic wok;
  logic oe;
  logic [7:0] r, a, b;

  sepcl_top #(.PROG_CYCLES(PROG)) u_sepcl_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .sck_i(sck),
    .cs_n_i(cs_n), .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n_i), .so_o(so), .so_oe_o(so_oe),
    .write_in_progress_o(write_in_progress), .write_enable_latch_o(write_enable_latch), .protect_pin_enable_o(ppe_o),
    .block_guard_hi_o(bgh), .block_guard_lo_o(bgl));
  sepcl_master u_sepcl_master (.so_i(so), .so_oe_i(so_oe), .sck_o(sck), .cs_n_o(cs_n), .si_o(si),
    .hold_n_o(hold_n));

  // System clock and a cycle ceiling that cuts a hang short.
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic guarded(input logic [11:0] ad, input logic [1:0] g);
    case (g)
      2'b00: return 1'b0;
      2'b01: return ad >= 12'hC00;
      2'b10: return ad >= 12'h800;
      default: return 1'b1;
    endcase
  endfunction

  // One frame: an opcode followed by nb zero bits.
  task automatic cmd(input logic [7:0] op, input int nb);
    u_sepcl_master.start();
    u_sepcl_master.xfer(op, 8, r);
    for (int k = nb; k > 0; k -= 8) u_sepcl_master.xfer(8'h00, (k > 8) ? 8 : k, r);
    u_sepcl_master.stop();
  endtask

  task automatic rds(input logic [7:0] exp);
    u_sepcl_master.start();
    u_sepcl_master.xfer(8'h05, 8, r);
    u_sepcl_master.xfer(8'h00, 8, r);
    u_sepcl_master.stop();
    chk(r, exp);
  endtask

  task automatic rd(input logic [15:0] ad, input int n);
    logic [11:0] p;
    p = ad[11:0];
    u_sepcl_master.start();
    u_sepcl_master.xfer(8'h03, 8, r);
    u_sepcl_master.xfer(ad[15:8], 8, r);
    u_sepcl_master.xfer(ad[7:0], 8, r);
    repeat (n) begin
      u_sepcl_master.xfer(8'h00, 8, r);
      chk(r, mem[p]);
      p = p + 12'h001;
    end
    u_sepcl_master.stop();
    chk(8'(so_oe), 8'h00);
  endtask

  // Sets the latch, sends a page write of n bytes plus tail stray bits, checks busy.
  task automatic wr(input logic [15:0] ad, input logic [7:0] d0, input int n, input int tail);
    wok = !guarded(ad[11:0], bg) && tail == 0;
    cmd(8'h06, 0);
    u_sepcl_master.start();
    u_sepcl_master.xfer(8'h02, 8, r);
    u_sepcl_master.xfer(ad[15:8], 8, r);
    u_sepcl_master.xfer(ad[7:0], 8, r);
    for (int i = 0; i < n; i++) begin
      u_sepcl_master.xfer(8'(d0 + i), 8, r);
      if (wok) mem[{ad[11:5], 5'(ad[4:0] + i)}] = 8'(d0 + i);
    end
    if (tail > 0) u_sepcl_master.xfer(8'h00, tail, r);
    u_sepcl_master.stop();
    @(negedge clock_i);
    chk(8'(write_in_progress), 8'(wok));
  endtask

  // Waits out programming and checks its length and the latch afterwards.
  task automatic idle(input logic ok);
    int i;
    for (i = 0; i < 2 * PROG && write_in_progress !== 1'b0; i++) @(negedge clock_i);
    chk(8'(i <= PROG), 8'h01);
    if (ok) chk(8'(write_enable_latch), 8'h00);
  endtask

  // Status write; drop pulls the protect pin low once programming has begun.
  task automatic wrs(input logic [7:0] v, input logic drop);
    logic ok;
    ok = !(ppe && !wp_n_i);
    cmd(8'h06, 0);
    u_sepcl_master.start();
    u_sepcl_master.xfer(8'h01, 8, r);
    u_sepcl_master.xfer(v, 8, r);
    u_sepcl_master.stop();
    if (drop) @(negedge clock_i) wp_n_i = 1'b0;
    if (ok) {ppe, bg} = {v[7], v[3:2]};
    idle(ok);
    if (!ok) chk(8'(write_enable_latch), 8'h01);
    chk(8'({ppe_o, bgh, bgl}), 8'({ppe, bg}));
  endtask

  // Main sequence.
  initial begin
    rst_n_i = 1'b0;
    wp_n_i = 1'b1;
    repeat (20) @(negedge clock_i);
    rst_n_i = 1'b1;
    repeat (5) @(negedge clock_i);
    chk(8'({so_oe, write_in_progress, write_enable_latch, ppe_o, bgh, bgl}), 8'h00);
    rds(8'h00);
    cmd(8'h06, 0);
    rds(8'h02);
    cmd(8'h04, 0);
    rds(8'h00);
    cmd(8'h06, 3);
    rds(8'h00);
    cmd(8'hFF, 32);
    chk(8'(u_sepcl_master.oe_seen), 8'h00);
    wr(16'h01FE, 8'h10, 4, 0);
    rds(8'h03);
    cmd(8'h03, 32);
    chk(8'(u_sepcl_master.oe_seen), 8'h00);
    idle(1'b1);
    rd(16'hF1E0, 2);
    rd(16'h01FE, 2);
    wr(16'h0FFF, 8'hA5, 1, 0);
    idle(1'b1);
    wr(16'h0000, 8'h5A, 1, 0);
    idle(1'b1);
    u_sepcl_master.start();
    u_sepcl_master.xfer(8'h03, 8, r);
    u_sepcl_master.xfer(8'h0F, 8, r);
    u_sepcl_master.xfer(8'hFF, 8, r);
    u_sepcl_master.xfer(8'h00, 8, a);
    u_sepcl_master.pause(3, oe);
    u_sepcl_master.xfer(8'h00, 8, b);
    u_sepcl_master.stop();
    chk(a, 8'hA5);
    chk(8'(oe), 8'h00);
    chk(b, 8'h5A);
    wr(16'h0300, 8'h77, 1, 3);
    idle(1'b0);
    wrs(8'h8C, 1'b0);
    wrs(8'h88, 1'b1);
    wrs(8'h00, 1'b0);
    @(negedge clock_i) wp_n_i = 1'b1;
    wrs(8'h04, 1'b0);
    @(negedge clock_i) wp_n_i = 1'b0;
    wrs(8'h08, 1'b0);
    for (int g = 0; g < 4; g++) begin
      wrs(8'(g << 2), 1'b0);
      foreach (tgt[k]) begin
        wr({4'h0, tgt[k]}, 8'(k + 4 * g), 1, 0);
        idle(wok);
      end
    end
    rd(16'h07FF, 2);
    rd(16'h0BFF, 2);
    tally_and_finish();
  end
endmodule
